// ===== src/lacs_scaler.v
// Load adaptive current scaler with stall, chopper and index diagnostics.
// Assumes all inputs synchronous to clk_sys; load_valid pulses per result.
//
// Summary of operation
// R1: Low load raises scale by 1,2,4,8
// R2: Decrement by one after 32,8,2,1 highs
// R3: Floor is half or quarter of run
// R4: Disable when step period above low threshold
// R5: Disable when step period below high threshold
// R6: Report actual scale as 5-bit status
// R7: Load source follows active chopper mode
// R8: Filter bit cuts update rate by four
// R9: Below low velocity use run or hold
// R10: Per pin source and output type select
// R11: First pin low during power-on reset
// R12: Stall only inside velocity condition
// R13: Chopper on-state alternates both coils outside voltage mode
// R14: Index pulses at microstep counter zero
// R15: Index lasts one microstep
// R16: Controller treats stall as stop switch
// R17: Lower threshold is field times 32
// R18: Upper threshold is (min+hyst+1) times 32
// R19: Scale saturates at ceiling and floor
// R20: Disabled scaling returns to run current
`timescale 1ns/1ps
`include "lacs_regs.vh"
module lacs_scaler #(
    parameter LOAD_W   = `LACS_LOAD_W,
    parameter PERIOD_W = `LACS_PERIOD_W
) (
    input  wire                clk_sys,
    input  wire                rst_n,

    input  wire                por_active,

    input  wire [1:0]          current_increment_step,
    input  wire [1:0]          current_decrement_rate,
    input  wire [3:0]          lower_load_threshold,
    input  wire [3:0]          upper_load_hysteresis,
    input  wire                min_current_quarter,
    input  wire                load_filter_en,

    input  wire [PERIOD_W-1:0] adaptive_low_velocity_threshold,
    input  wire [PERIOD_W-1:0] adaptive_high_velocity_threshold,
    input  wire [PERIOD_W-1:0] measured_step_period,

    input  wire [4:0]          run_current,
    input  wire [4:0]          hold_current,
    input  wire                standstill,

    input  wire                voltage_mode,
    input  wire                cycle_load_valid,
    input  wire [LOAD_W-1:0]   cycle_mode_load_result,
    input  wire                voltage_load_valid,
    input  wire [LOAD_W-1:0]   voltage_mode_load_result,
    input  wire [LOAD_W-1:0]   voltage_mode_stall_threshold,

    input  wire                chop_on_a,
    input  wire                chop_on_b,
    input  wire [9:0]          microstep_count,

    input  wire [1:0]          diag_a_source,
    input  wire [1:0]          diag_b_source,
    input  wire                diag_a_push_pull,
    input  wire                diag_b_push_pull,

    output reg  [4:0]          current_scale_r,
    output reg  [4:0]          actual_scale_r,
    output reg                 stall_r,

    output wire                diagnostic_out_a_o,
    output wire                diagnostic_out_a_oe,
    output wire                diagnostic_out_b_o,
    output wire                diagnostic_out_b_oe
);
    // -------------------------------------------------------------------
    // Thresholds and enable window
    // -------------------------------------------------------------------
    wire [LOAD_W-1:0] thr_lo = {{(LOAD_W-9){1'b0}}, lower_load_threshold,
                                {`LACS_THR_SHIFT{1'b0}}}; // R17
    // Sum of two 4-bit fields plus one never exceeds 31
    wire [4:0] hi_sum = {1'b0, lower_load_threshold}
                      + {1'b0, upper_load_hysteresis} + 5'h01;
    wire [LOAD_W:0] thr_hi = {{(LOAD_W-9){1'b0}}, hi_sum,
                              {`LACS_THR_SHIFT{1'b0}}}; // R18

    // -------------------------------------------------------------------
    // Velocity window
    // -------------------------------------------------------------------
    wire vel_ok_lo = measured_step_period <= adaptive_low_velocity_threshold; // R4 R12
    wire vel_ok_hi = measured_step_period >= adaptive_high_velocity_threshold; // R5
    wire scale_en = vel_ok_lo && vel_ok_hi && (lower_load_threshold != 4'h0); // R17

    // -------------------------------------------------------------------
    // Load source and rate filter
    // -------------------------------------------------------------------
    wire              ld_valid = voltage_mode ? voltage_load_valid : cycle_load_valid; // R7
    wire [LOAD_W-1:0] ld_val   = voltage_mode ? voltage_mode_load_result
                                              : cycle_mode_load_result; // R7

    // -------------------------------------------------------------------
    // Rate filter: every fourth valid result when enabled
    // -------------------------------------------------------------------
    reg  [1:0] filt_cnt_r;
    wire       upd = ld_valid && (!load_filter_en || filt_cnt_r == `LACS_FILT_DIV); // R8

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            filt_cnt_r <= 2'h0;
        else if (ld_valid)
            filt_cnt_r <= filt_cnt_r + 2'h1;
    end

    // -------------------------------------------------------------------
    // Scale regulation
    // -------------------------------------------------------------------
    wire [4:0] floor_v = min_current_quarter ? {2'b00, run_current[4:2]}
                                             : {1'b0, run_current[4:1]}; // R3
    reg  [3:0] up_step;
    reg  [5:0] dn_need;

    // -------------------------------------------------------------------
    // Increment step decode
    // -------------------------------------------------------------------
    always @* begin
        case (current_increment_step)
            2'h0:    up_step = 4'h1;
            2'h1:    up_step = 4'h2;
            2'h2:    up_step = 4'h4;
            default: up_step = 4'h8;
        endcase // R1
    end

    // -------------------------------------------------------------------
    // Decrement count decode
    // -------------------------------------------------------------------
    always @* begin
        case (current_decrement_rate)
            2'h0:    dn_need = `LACS_DN_CNT0;
            2'h1:    dn_need = `LACS_DN_CNT1;
            2'h2:    dn_need = `LACS_DN_CNT2;
            default: dn_need = `LACS_DN_CNT3;
        endcase // R2
    end

    // -------------------------------------------------------------------
    // Load classification against both thresholds
    // -------------------------------------------------------------------
    wire ld_low  = upd && (ld_val < thr_lo); // R1 R17
    wire ld_high = upd && ({1'b0, ld_val} >= thr_hi); // R2 R18
    // Samples are ignored while the scale is still being clamped
    wire in_band = (current_scale_r <= run_current) && (current_scale_r >= floor_v); // R19

    // -------------------------------------------------------------------
    // Decrement counter: high readings count, a low reading clears
    // -------------------------------------------------------------------
    reg  [5:0] dn_cnt_r;
    reg  [5:0] dn_cnt_nxt;
    reg        dn_hit;
    wire [5:0] dn_cnt_inc = dn_cnt_r + 6'h01;
    always @* begin
        dn_cnt_nxt = dn_cnt_r;
        dn_hit     = 1'b0;
        if (!scale_en) begin
            dn_cnt_nxt = 6'h00;
        end else if (!in_band) begin
            dn_cnt_nxt = dn_cnt_r;
        end else if (ld_low) begin
            dn_cnt_nxt = 6'h00;
        end else if (ld_high) begin
            if (dn_cnt_inc >= dn_need) begin
                dn_cnt_nxt = 6'h00;
                dn_hit     = 1'b1; // R2
            end else begin
                dn_cnt_nxt = dn_cnt_inc; // R2
            end
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            dn_cnt_r <= 6'h00;
        else
            dn_cnt_r <= dn_cnt_nxt;
    end

    // -------------------------------------------------------------------
    // Scale next value, saturating at ceiling and floor
    // -------------------------------------------------------------------
    reg  [4:0] scale_nxt;
    wire [5:0] up_sum = {1'b0, current_scale_r} + {2'b00, up_step};
    always @* begin
        scale_nxt = current_scale_r;
        if (!scale_en)
            scale_nxt = run_current; // R20
        else if (current_scale_r > run_current)
            scale_nxt = run_current; // R19
        else if (current_scale_r < floor_v)
            scale_nxt = floor_v; // R19
        else if (ld_low && (up_sum > {1'b0, run_current}))
            scale_nxt = run_current; // R19
        else if (ld_low)
            scale_nxt = up_sum[4:0]; // R1
        else if (dn_hit && (current_scale_r > floor_v))
            scale_nxt = current_scale_r - 5'h01; // R2 R19
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            current_scale_r <= `LACS_CUR_RST;
        else
            current_scale_r <= scale_nxt;
    end

    // -------------------------------------------------------------------
    // Applied current: adaptive or normal setting
    // -------------------------------------------------------------------
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            actual_scale_r <= `LACS_CUR_RST;
        else if (standstill)
            actual_scale_r <= hold_current; // R9
        else if (!vel_ok_lo)
            actual_scale_r <= run_current; // R9
        else
            actual_scale_r <= current_scale_r; // R6
    end

    // -------------------------------------------------------------------
    // Diagnostic sources
    // -------------------------------------------------------------------
    wire stall_cond = voltage_mode
                    ? (voltage_mode_load_result < voltage_mode_stall_threshold)
                    : (cycle_mode_load_result == {LOAD_W{1'b0}});
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            stall_r <= 1'b0;
        else
            stall_r <= stall_cond && vel_ok_lo; // R12
    end

    // -------------------------------------------------------------------
    // Chopper on-state, one coil per clock
    // -------------------------------------------------------------------
    reg chop_sel_r;
    reg chop_r;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            chop_sel_r <= 1'b0;
            chop_r     <= 1'b0;
        end else begin
            chop_sel_r <= ~chop_sel_r;
            chop_r     <= !voltage_mode && (chop_sel_r ? chop_on_b : chop_on_a); // R13
        end
    end

    // -------------------------------------------------------------------
    // Index: high while the microstep counter sits at zero
    // -------------------------------------------------------------------
    reg index_r;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            index_r <= 1'b0;
        else
            index_r <= microstep_count == 10'h000; // R14 R15
    end

    // -------------------------------------------------------------------
    // Per pin source select and output stage
    // -------------------------------------------------------------------
    wire [3:0] pin_src = {diag_b_source, diag_a_source};
    wire [1:0] pin_pp  = {diag_b_push_pull, diag_a_push_pull};
    wire [1:0] pin_por = {1'b0, por_active}; // R11
    wire [1:0] pin_o;
    wire [1:0] pin_oe;
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_pin
            reg act;
            always @* begin
                case (pin_src[2*g+1:2*g])
                    `LACS_SRC_STALL: act = stall_r;
                    `LACS_SRC_CHOP:  act = chop_r;
                    `LACS_SRC_INDEX: act = index_r;
                    `LACS_SRC_NONE:  act = 1'b0;
                    default:         act = 1'b0;
                endcase // R10
            end

            lacs_diag_pin u_pin (
                .clk_sys   (clk_sys),
                .rst_n     (rst_n),
                .active    (act),
                .push_pull (pin_pp[g]),
                .force_low (pin_por[g]),
                .pin_o     (pin_o[g]),
                .pin_oe    (pin_oe[g])
            );
        end
    endgenerate

    assign diagnostic_out_a_o  = pin_o[0];
    assign diagnostic_out_a_oe = pin_oe[0];
    assign diagnostic_out_b_o  = pin_o[1];
    assign diagnostic_out_b_oe = pin_oe[1];
endmodule // lacs_scaler

// ===== src/lacs_regs.vh
// Constants for the load adaptive current scaler and diagnostic outputs.
// Assumes inclusion by the design files below; definitions only.
`ifndef LACS_REGS_VH
`define LACS_REGS_VH
// -----------------------------------------------------------------------
// Field widths and scaling
// -----------------------------------------------------------------------
`define LACS_LOAD_W        10
`define LACS_PERIOD_W      20
`define LACS_CUR_W         5
`define LACS_THR_SHIFT     5
// -----------------------------------------------------------------------
// Decrement measurement counts per code
// -----------------------------------------------------------------------
`define LACS_DN_CNT0       6'h20
`define LACS_DN_CNT1       6'h08
`define LACS_DN_CNT2       6'h02
`define LACS_DN_CNT3       6'h01
// -----------------------------------------------------------------------
// Diagnostic source select codes
// -----------------------------------------------------------------------
`define LACS_SRC_STALL     2'h0
`define LACS_SRC_CHOP      2'h1
`define LACS_SRC_INDEX     2'h2
`define LACS_SRC_NONE      2'h3
// -----------------------------------------------------------------------
// Filter rate divider and reset values
// -----------------------------------------------------------------------
`define LACS_FILT_DIV      2'h3
`define LACS_CUR_RST       5'h00
`endif

// ===== src/lacs_diag_pin.v
// One configurable diagnostic output pin.
// Assumes the source level is synchronous to clk_sys.
`timescale 1ns/1ps
module lacs_diag_pin (
    input  wire       clk_sys,
    input  wire       rst_n,
    input  wire       active,
    input  wire       push_pull,
    input  wire       force_low,
    output reg        pin_o,
    output reg        pin_oe
);
    // -------------------------------------------------------------------
    // Open drain pulls low when active; push-pull drives active high
    // -------------------------------------------------------------------
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_o  <= 1'b0;
            pin_oe <= 1'b1;
        end else if (force_low) begin
            pin_o  <= 1'b0; // R11
            pin_oe <= 1'b1;
        end else if (push_pull) begin
            pin_o  <= active; // R10
            pin_oe <= 1'b1;
        end else begin
            pin_o  <= 1'b0; // R10
            pin_oe <= active;
        end
    end
endmodule // lacs_diag_pin

// ===== tb/lacs_scaler_monitor.sv
// Assertions on the load adaptive current scaler ports.
// Assumes the bind below; one clock domain.
`timescale 1ns/1ps
module lacs_scaler_monitor #(
    parameter PERIOD_W = 20
) (
    input logic                clk_sys,
    input logic                rst_n,
    input logic                por_active,
    input logic [1:0]          current_increment_step,
    input logic [3:0]          lower_load_threshold,
    input logic                min_current_quarter,
    input logic                load_filter_en,
    input logic [PERIOD_W-1:0] adaptive_low_velocity_threshold,
    input logic [PERIOD_W-1:0] adaptive_high_velocity_threshold,
    input logic [PERIOD_W-1:0] measured_step_period,
    input logic [4:0]          run_current,
    input logic [4:0]          hold_current,
    input logic                standstill,
    input logic                voltage_mode,
    input logic                cycle_load_valid,
    input logic [9:0]          cycle_mode_load_result,
    input logic                diag_b_push_pull,
    input logic [4:0]          current_scale_r,
    input logic [4:0]          actual_scale_r,
    input logic                stall_r,
    input logic                diagnostic_out_a_o,
    input logic                diagnostic_out_a_oe,
    input logic                diagnostic_out_b_o,
    input logic                diagnostic_out_b_oe
);
    wire       slow = measured_step_period > adaptive_low_velocity_threshold;
    wire       en   = lower_load_threshold != 4'h0 && !slow
                      && measured_step_period >= adaptive_high_velocity_threshold;
    wire [5:0] up   = {1'b0, current_scale_r} + (6'h01 << current_increment_step);
    wire [4:0] flr  = min_current_quarter ? run_current >> 2 : run_current >> 1;
    wire       low  = cycle_mode_load_result < {lower_load_threshold, 5'h00};
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_inc_step: assert property (en && !voltage_mode && !load_filter_en && cycle_load_valid
        && low && current_scale_r >= flr && up <= {1'b0, run_current}
        |=> {1'b0, current_scale_r} == $past(up)) else $error("scale step wrong");
    a_scale_run: assert property (!en |=> current_scale_r == $past(run_current))
        else $error("scale not back at run current");
    a_scale_range: assert property ((en && $stable(min_current_quarter)) [*2]
        |-> current_scale_r <= run_current && current_scale_r >= flr)
        else $error("scale out of range");
    a_actual_scale: assert property (!standstill && en
        |=> actual_scale_r == $past(current_scale_r)) else $error("applied scale wrong");
    a_hold_applied: assert property (standstill |=> actual_scale_r == $past(hold_current))
        else $error("hold current not applied");
    a_stall_gate: assert property (slow |=> !stall_r) else $error("stall when slow");
    a_pin_por: assert property (por_active [*3]
        |-> !diagnostic_out_a_o && diagnostic_out_a_oe) else $error("pin a not low");
    a_open_drain: assert property (!diag_b_push_pull [*3] |-> !diagnostic_out_b_o)
        else $error("open drain drives high");
    a_push_pull: assert property (diag_b_push_pull [*3] |-> diagnostic_out_b_oe)
        else $error("push-pull not driven");
endmodule // lacs_scaler_monitor
bind lacs_scaler lacs_scaler_monitor #(.PERIOD_W(PERIOD_W)) u_mon (.*);

// ===== tb/lacs_ctrl_model.sv
// Motion controller watching one diagnostic pin.
// Assumes a board pull-up on the pin.
`timescale 1ns/1ps
module lacs_ctrl_model (
    input  logic clk_sys,
    input  logic push_pull,
    input  logic pin_o,
    input  logic pin_oe,
    output logic pin_lvl,
    output logic stop_r
);
    // Released line floats to the pull-up level
    assign pin_lvl = pin_oe ? pin_o : 1'b1;
    always @(posedge clk_sys) stop_r <= push_pull ? pin_lvl : !pin_lvl;
endmodule // lacs_ctrl_model

// ===== tb/lacs_scaler_tb.sv
// Testbench for the load adaptive current scaler.
// Assumes lacs_scaler, the controller model and the monitor.
`timescale 1ns/1ps
module lacs_scaler_tb;
    logic clk_sys = 1'b0, rst_n = 1'b0, por_active = 1'b0, min_current_quarter = 1'b0;
    logic load_filter_en = 1'b0, standstill = 1'b0, voltage_mode = 1'b0, chop_on_a = 1'b0;
    logic cycle_load_valid = 1'b0, voltage_load_valid = 1'b0, chop_on_b = 1'b0;
    logic diag_a_push_pull = 1'b0, diag_b_push_pull = 1'b1;
    logic [1:0] current_increment_step = 2'h0, current_decrement_rate = 2'h0;
    logic [1:0] diag_a_source = 2'h0, diag_b_source = 2'h2;
    logic [3:0] lower_load_threshold = 4'h0, upper_load_hysteresis = 4'h2;
    logic [19:0] adaptive_low_velocity_threshold = 20'h003E8, measured_step_period = 20'h001F4;
    logic [19:0] adaptive_high_velocity_threshold = 20'h00064;
    logic [4:0] run_current = 5'h14, hold_current = 5'h06, s;
    logic [9:0] cycle_mode_load_result = 10'h0A0, voltage_mode_load_result = 10'h0A0;
    logic [9:0] voltage_mode_stall_threshold = 10'h008, microstep_count = 10'h001;
    wire  [4:0] current_scale_r, actual_scale_r;
    wire        stall_r, diagnostic_out_a_o, diagnostic_out_a_oe, lvl_a, stop_a;
    wire        diagnostic_out_b_o, diagnostic_out_b_oe, lvl_b, stop_b;
    int         error_cnt = 0, checks = 0, n;
    lacs_scaler u_dut (.*);
    lacs_ctrl_model u_ctl_a (.clk_sys(clk_sys), .push_pull(diag_a_push_pull),
        .pin_o(diagnostic_out_a_o), .pin_oe(diagnostic_out_a_oe), .pin_lvl(lvl_a), .stop_r(stop_a));
    lacs_ctrl_model u_ctl_b (.clk_sys(clk_sys), .push_pull(diag_b_push_pull),
        .pin_o(diagnostic_out_b_o), .pin_oe(diagnostic_out_b_oe), .pin_lvl(lvl_b), .stop_r(stop_b));
    always #12.5 clk_sys = ~clk_sys;
    task ck(input logic [4:0] got, input logic [4:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task w;
        repeat (3) @(negedge clk_sys);
    endtask
    // One load result pulse, cycle source when v is low
    task smp(input logic v, input logic [9:0] ld);
        cycle_mode_load_result = ld;
        voltage_mode_load_result = ld;
        cycle_load_valid = !v;
        voltage_load_valid = v;
        @(negedge clk_sys);
        cycle_load_valid = 1'b0;
        voltage_load_valid = 1'b0;
        @(negedge clk_sys);
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        w;
        rst_n = 1'b1;
        w;
        ck(current_scale_r, 5'h14);
        lower_load_threshold = 4'h4;
        s = 5'h14;
        for (int c = 0; c < 4; c++) begin
            current_decrement_rate = c[1:0];
            n = (c == 0) ? 6'h20 : (c == 1) ? 6'h08 : (c == 2) ? 6'h02 : 6'h01;
            repeat (n - 1) smp(1'b0, 10'h12C);
            ck(current_scale_r, s);
            smp(1'b0, 10'h0E0);
            s = s - 5'h01;
            ck(current_scale_r, s);
        end
        for (int c = 0; c < 4; c++) begin
            current_increment_step = c[1:0];
            smp(1'b0, 10'h07F);
            s = s + (5'h01 << c);
            if (s > 5'h14) s = 5'h14;
            ck(current_scale_r, s);
        end
        load_filter_en = 1'b1;
        repeat (4) smp(1'b0, 10'h12C);
        ck(current_scale_r, 5'h13);
        load_filter_en = 1'b0;
        min_current_quarter = 1'b1;
        repeat (16) smp(1'b0, 10'h12C);
        ck(current_scale_r, 5'h05);
        min_current_quarter = 1'b0;
        w;
        ck(actual_scale_r, 5'h0A);
        voltage_mode = 1'b1;
        smp(1'b0, 10'h010);
        ck(current_scale_r, 5'h0A);
        smp(1'b1, 10'h010);
        ck(current_scale_r, 5'h12);
        voltage_mode = 1'b0;
        measured_step_period = 20'h00032;
        w;
        ck(current_scale_r, 5'h14);
        measured_step_period = 20'h001F4;
        smp(1'b0, 10'h12C);
        standstill = 1'b1;
        w;
        ck(actual_scale_r, 5'h06);
        standstill = 1'b0;
        cycle_mode_load_result = 10'h000;
        measured_step_period = 20'h007D0;
        w;
        ck(current_scale_r, 5'h14);
        ck(stall_r, 1'b0);
        measured_step_period = 20'h003E8;
        w;
        ck(stall_r, 1'b1);
        ck(stop_a, 1'b1);
        diag_a_push_pull = 1'b1;
        w;
        ck(lvl_a, 1'b1);
        por_active = 1'b1;
        w;
        ck(lvl_a, 1'b0);
        ck(lvl_b, 1'b0);
        microstep_count = 10'h000;
        w;
        ck(lvl_b, 1'b1);
        diag_b_push_pull = 1'b0;
        w;
        ck(lvl_b, 1'b0);
        diag_b_push_pull = 1'b1;
        diag_b_source = 2'h1;
        chop_on_a = 1'b1;
        chop_on_b = 1'b1;
        w;
        ck(lvl_b, 1'b1);
        chop_on_a = 1'b0;
        chop_on_b = 1'b0;
        w;
        ck(lvl_b, 1'b0);
        voltage_mode = 1'b1;
        w;
        ck(stall_r, 1'b0);
        voltage_mode_load_result = 10'h004;
        w;
        ck(stall_r, 1'b1);
        print_verdict;
    end
endmodule // lacs_scaler_tb
